// ### rac_alarm_ctrl.sv
// Top of the RTC alarm compare and control registers with a Wishbone slave.
`timescale 1ns/1ps
// What this block does
// - Compare only enabled alarm fields; alarm when all enabled fields match.
// - Hour alarm holds BCD 00 to 23; bit 6 reads zero.
// - Weekday alarm is three bits, 0 to 6; bits 6 to 3 read zero.
// - Month alarm holds BCD 01 to 12; bits 6 and 5 read zero.
// - Power-on reset clears alarm enables; alarm values survive all resets.
// - Flag control resets to 00; manual reset keeps carry flag; standby keeps all.
// - Carry flag sets on sub-second or seconds counter increment.
// - Writing 0 clears carry flag, writing 1 sets it.
// - Carry interrupt asserted while carry flag and its enable are set.
// - Alarm interrupt asserted while alarm flag and its enable are set.
// - Alarm flag sets when all enabled fields match the running time.
// - Writing 0 clears alarm flag; writing 1 leaves it unchanged.
// - Flag control bits 6, 5, 2, 1 read zero.
// - Period control resets to 09; manual reset keeps oscillator enable and start.
// - Periodic flag sets on each selected period and requests an interrupt.
// - Period select zero gives no periodic events.
// - Codes 1 to 7 select 1/256, 1/64, 1/16, 1/4, 1/2, 1, 2 seconds.
// - Adjust write rounds seconds to 00 or next minute and resets divider; reads 0.
// - Divider reset write pulses divider reset, reads 0; start clear halts counters.
module rac_alarm_ctrl (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                manual_rst_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [4:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire rac_pkg::rac_time_t   time_i,
  input  wire rac_pkg::rac_events_t events_i,
  output logic                     carry_irq_o,
  output logic                     alarm_irq_o,
  output logic                     periodic_irq_o,
  output logic                     osc_enable_o,
  output logic                     count_run_o,
  output logic                     div_reset_o,
  output logic                     adjust_round_down_o,
  output logic                     adjust_round_up_o
);
  logic       carry_flag_q;
  logic       alarm_flag_q;
  logic       carry_ie_q;
  logic       alarm_ie_q;
  logic       periodic_flag_q;
  logic [2:0] period_sel_q;
  logic       osc_en_q;
  logic       start_q;
  logic [7:0] taps_prev_q;
  logic       ack_q;
  logic [31:0] rdata_q;
  logic       div_reset_q;
  logic       adj_dn_q;
  logic       adj_up_q;
  logic       carry_irq_q;
  logic       alarm_irq_q;
  logic       periodic_irq_q;

  logic       req;
  logic       wr;
  logic [7:0] wbyte;
  logic [5:0] field_wr;
  logic [7:0] field_rd [6];
  logic [5:0] field_en;
  logic [5:0] field_hit;
  logic [7:0] field_cnt [6];
  logic       wr_flag;
  logic       wr_period;
  logic       alarm_match;
  logic       period_event;
  logic [7:0] tap_rise;
  logic [7:0] flag_rd;
  logic [7:0] period_rd;
  logic [7:0] rd_byte;
  logic       carry_set;
  logic       adjust_wr;
  logic       sec_upper_half;

  // Registers sit on even byte offsets, so the lane follows address bit 1.
  assign req   = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr    = req && wb_we_i && (wb_adr_i[1] ? wb_sel_i[2] : wb_sel_i[0]);
  assign wbyte = wb_adr_i[1] ? wb_dat_i[23:16] : wb_dat_i[7:0];

  assign field_wr[0] = wr && (wb_adr_i == rac_pkg::ADDR_SECOND_ALARM);
  assign field_wr[1] = wr && (wb_adr_i == rac_pkg::ADDR_MINUTE_ALARM);
  assign field_wr[2] = wr && (wb_adr_i == rac_pkg::ADDR_HOUR_ALARM);
  assign field_wr[3] = wr && (wb_adr_i == rac_pkg::ADDR_WEEKDAY_ALARM);
  assign field_wr[4] = wr && (wb_adr_i == rac_pkg::ADDR_DATE_ALARM);
  assign field_wr[5] = wr && (wb_adr_i == rac_pkg::ADDR_MONTH_ALARM);
  assign wr_flag     = wr && (wb_adr_i == rac_pkg::ADDR_FLAG_CTRL);
  assign wr_period   = wr && (wb_adr_i == rac_pkg::ADDR_PERIOD_CTRL);

  assign field_cnt[0] = time_i.second;
  assign field_cnt[1] = time_i.minute;
  assign field_cnt[2] = time_i.hour;
  assign field_cnt[3] = time_i.weekday;
  assign field_cnt[4] = time_i.date;
  assign field_cnt[5] = time_i.month;

  localparam logic [7:0] FIELD_MASK [6] = '{
    rac_pkg::SEC_MIN_MASK, rac_pkg::SEC_MIN_MASK, rac_pkg::HOUR_MASK,
    rac_pkg::WEEKDAY_MASK, rac_pkg::DATE_MASK, rac_pkg::MONTH_MASK
  };

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_field
      rac_alarm_field #(
        .VALUE_MASK (FIELD_MASK[g])
      ) u_field (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .wr_i      (field_wr[g]),
        .wdata_i   (wbyte),
        .count_i   (field_cnt[g]),
        .rdata_o   (field_rd[g]),
        .enabled_o (field_en[g]),
        .hit_o     (field_hit[g])
      );
    end
  endgenerate

  assign alarm_match = events_i.counters_updated && (|field_en) && (&field_hit);

  // Carry flag: a hardware increment wins over a software clear in the same cycle.
  assign carry_set = events_i.sub_second_tick || events_i.seconds_tick;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      carry_flag_q <= 1'b0;
    end else if (carry_set) begin
      carry_flag_q <= 1'b1;
    end else if (wr_flag) begin
      carry_flag_q <= wbyte[rac_pkg::CARRY_FLAG_BIT];
    end
  end

  // Manual reset leaves the carry flag as it was; undefined is satisfied by holding.
  always_ff @(posedge clk_i) begin
    if (rst_i || manual_rst_i) begin
      carry_ie_q <= 1'b0;
    end else if (wr_flag) begin
      carry_ie_q <= wbyte[rac_pkg::CARRY_IRQ_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || manual_rst_i) begin
      alarm_ie_q <= 1'b0;
    end else if (wr_flag) begin
      alarm_ie_q <= wbyte[rac_pkg::ALARM_IRQ_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || manual_rst_i) begin
      alarm_flag_q <= 1'b0;
    end else if (alarm_match) begin
      alarm_flag_q <= 1'b1;
    end else if (wr_flag && !wbyte[rac_pkg::ALARM_FLAG_BIT]) begin
      alarm_flag_q <= 1'b0;
    end
  end

  // Period events come from rising edges of the divider taps.
  assign tap_rise = events_i.div_taps & ~taps_prev_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      taps_prev_q <= 8'h00;
    end else begin
      taps_prev_q <= events_i.div_taps;
    end
  end

  // Tap index equals select code; tap 0 is unused so code 0 never fires.
  always_comb begin
    case (period_sel_q)
      3'h1:    period_event = tap_rise[1];
      3'h2:    period_event = tap_rise[2];
      3'h3:    period_event = tap_rise[3];
      3'h4:    period_event = tap_rise[4];
      3'h5:    period_event = tap_rise[5];
      3'h6:    period_event = tap_rise[6];
      3'h7:    period_event = tap_rise[7];
      default: period_event = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || manual_rst_i) begin
      periodic_flag_q <= 1'b0;
      period_sel_q    <= rac_pkg::PERIOD_CTRL_RESET[6:4];
    end else begin
      if (period_event) begin
        periodic_flag_q <= 1'b1;
      end else if (wr_period) begin
        periodic_flag_q <= wbyte[rac_pkg::PERIODIC_FLAG_BIT];
      end
      if (wr_period) begin
        period_sel_q <= wbyte[rac_pkg::PERIOD_SELECT_LSB +: 3];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_en_q <= rac_pkg::PERIOD_CTRL_RESET[rac_pkg::OSC_ENABLE_BIT];
    end else if (wr_period) begin
      osc_en_q <= wbyte[rac_pkg::OSC_ENABLE_BIT];
    end
  end

  // Manual reset leaves the counters running; only power-on reset restarts them.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_q <= rac_pkg::PERIOD_CTRL_RESET[rac_pkg::COUNT_START_BIT];
    end else if (wr_period) begin
      start_q <= wbyte[rac_pkg::COUNT_START_BIT];
    end
  end

  // Adjust and divider reset are write strobes only, held for one cycle.
  assign adjust_wr      = wr_period && wbyte[rac_pkg::ADJUST_BIT];
  // Seconds are BCD, so a plain compare against 30 splits the minute in half.
  assign sec_upper_half = (time_i.second >= 8'h30);

  always_ff @(posedge clk_i) begin
    if (rst_i || manual_rst_i) begin
      div_reset_q <= 1'b0;
    end else begin
      div_reset_q <= adjust_wr || (wr_period && wbyte[rac_pkg::DIV_RESET_BIT]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || manual_rst_i) begin
      adj_dn_q <= 1'b0;
      adj_up_q <= 1'b0;
    end else begin
      adj_dn_q <= adjust_wr && !sec_upper_half;
      adj_up_q <= adjust_wr && sec_upper_half;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      carry_irq_q <= 1'b0;
    end else begin
      carry_irq_q <= carry_flag_q && carry_ie_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_irq_q <= 1'b0;
    end else begin
      alarm_irq_q <= alarm_flag_q && alarm_ie_q;
    end
  end

  // No separate enable exists for the periodic request, so it follows the flag.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      periodic_irq_q <= 1'b0;
    end else begin
      periodic_irq_q <= periodic_flag_q;
    end
  end

  assign flag_rd = {carry_flag_q, 2'b00, carry_ie_q, alarm_ie_q, 2'b00, alarm_flag_q}
                   & rac_pkg::FLAG_CTRL_RMASK;
  assign period_rd = {periodic_flag_q, period_sel_q, osc_en_q, 2'b00, start_q};

  always_comb begin
    case (wb_adr_i)
      rac_pkg::ADDR_SECOND_ALARM:  rd_byte = field_rd[0];
      rac_pkg::ADDR_MINUTE_ALARM:  rd_byte = field_rd[1];
      rac_pkg::ADDR_HOUR_ALARM:    rd_byte = field_rd[2];
      rac_pkg::ADDR_WEEKDAY_ALARM: rd_byte = field_rd[3];
      rac_pkg::ADDR_DATE_ALARM:    rd_byte = field_rd[4];
      rac_pkg::ADDR_MONTH_ALARM:   rd_byte = field_rd[5];
      rac_pkg::ADDR_FLAG_CTRL:     rd_byte = flag_rd;
      rac_pkg::ADDR_PERIOD_CTRL:   rd_byte = period_rd;
      default:                     rd_byte = 8'h00;
    endcase
  end

  // Unmapped addresses still acknowledge with zero data so the bus never hangs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // Read data is captured only on a taken request and then held for the master.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (req) begin
      rdata_q <= wb_adr_i[1] ? {8'h00, rd_byte, 16'h0000} : {24'h000000, rd_byte};
    end
  end

  assign wb_ack_o            = ack_q;
  assign wb_dat_o            = rdata_q;
  assign carry_irq_o         = carry_irq_q;
  assign alarm_irq_o         = alarm_irq_q;
  assign periodic_irq_o      = periodic_irq_q;
  assign osc_enable_o        = osc_en_q;
  assign count_run_o         = start_q;
  assign div_reset_o         = div_reset_q;
  assign adjust_round_down_o = adj_dn_q;
  assign adjust_round_up_o   = adj_up_q;
endmodule // rac_alarm_ctrl

// ### rac_pkg.sv
// Package with register map, field positions and reset values for the RTC alarm and control block.
package rac_pkg;

  localparam logic [4:0] ADDR_SECOND_ALARM  = 5'h10;
  localparam logic [4:0] ADDR_MINUTE_ALARM  = 5'h12;
  localparam logic [4:0] ADDR_HOUR_ALARM    = 5'h14;
  localparam logic [4:0] ADDR_WEEKDAY_ALARM = 5'h16;
  localparam logic [4:0] ADDR_DATE_ALARM    = 5'h18;
  localparam logic [4:0] ADDR_MONTH_ALARM   = 5'h1A;
  localparam logic [4:0] ADDR_FLAG_CTRL     = 5'h1C;
  localparam logic [4:0] ADDR_PERIOD_CTRL   = 5'h1E;

  localparam int ALARM_FIELD_ENABLE_BIT = 7;
  localparam int CARRY_FLAG_BIT         = 7;
  localparam int CARRY_IRQ_ENABLE_BIT   = 4;
  localparam int ALARM_IRQ_ENABLE_BIT   = 3;
  localparam int ALARM_FLAG_BIT         = 0;
  localparam int PERIODIC_FLAG_BIT      = 7;
  localparam int PERIOD_SELECT_LSB      = 4;
  localparam int OSC_ENABLE_BIT         = 3;
  localparam int ADJUST_BIT             = 2;
  localparam int DIV_RESET_BIT          = 1;
  localparam int COUNT_START_BIT        = 0;

  localparam logic [7:0] FLAG_CTRL_RESET   = 8'h00;
  localparam logic [7:0] PERIOD_CTRL_RESET = 8'h09;
  localparam logic [7:0] FLAG_CTRL_RMASK   = 8'h99;
  localparam logic [7:0] SEC_MIN_MASK      = 8'h7F;
  localparam logic [7:0] HOUR_MASK         = 8'h3F;
  localparam logic [7:0] WEEKDAY_MASK      = 8'h07;
  localparam logic [7:0] DATE_MASK         = 8'h3F;
  localparam logic [7:0] MONTH_MASK        = 8'h1F;

  typedef struct packed {
    logic [7:0] second;
    logic [7:0] minute;
    logic [7:0] hour;
    logic [7:0] weekday;
    logic [7:0] date;
    logic [7:0] month;
  } rac_time_t;

  typedef struct packed {
    logic sub_second_tick;
    logic seconds_tick;
    logic counters_updated;
    logic [7:0] div_taps;
  } rac_events_t;

endpackage

// ### rac_alarm_field.sv
// One alarm field register with its enable bit and gated compare.
`timescale 1ns/1ps
module rac_alarm_field #(
  parameter logic [7:0] VALUE_MASK = 8'h7F
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [7:0] count_i,
  output logic      [7:0] rdata_o,
  output logic            enabled_o,
  output logic            hit_o
);
  logic       enable_q;
  logic [6:0] value_q;

  // A field reset never touches the value, so the alarm time survives any reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_q <= 1'b0;
    end else if (wr_i) begin
      enable_q <= wdata_i[7];
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      value_q <= wdata_i[6:0] & VALUE_MASK[6:0];
    end
  end

  assign rdata_o   = {enable_q, value_q & VALUE_MASK[6:0]};
  assign enabled_o = enable_q;
  assign hit_o     = !enable_q || (value_q == (count_i[6:0] & VALUE_MASK[6:0]));
endmodule // rac_alarm_field

// ### rac_alarm_ctrl_asserts.sv
// Port-level checks for the RTC alarm and control block.
`timescale 1ns/1ps
module rac_alarm_ctrl_asserts (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                manual_rst_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [4:0]          wb_adr_i,
  input wire logic [3:0]          wb_sel_i,
  input wire logic [31:0]         wb_dat_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o,
  input wire rac_pkg::rac_time_t   time_i,
  input wire rac_pkg::rac_events_t events_i,
  input wire logic                carry_irq_o,
  input wire logic                alarm_irq_o,
  input wire logic                periodic_irq_o,
  input wire logic                osc_enable_o,
  input wire logic                count_run_o,
  input wire logic                div_reset_o,
  input wire logic                adjust_round_down_o,
  input wire logic                adjust_round_up_o
);
  logic wr_take;
  logic wr_per;
  logic rd_flag;
  logic rd_per;
  assign wr_take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
  assign wr_per = wr_take && wb_adr_i == rac_pkg::ADDR_PERIOD_CTRL && wb_sel_i[2];
  assign rd_flag = wb_ack_o && !wb_we_i && wb_adr_i == rac_pkg::ADDR_FLAG_CTRL;
  assign rd_per = wb_ack_o && !wb_we_i && wb_adr_i == rac_pkg::ADDR_PERIOD_CTRL;
  // Manual reset clears pulses and the alarm and periodic flags, so checks pause while either reset is high.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || manual_rst_i);
  a_carry_irq_gate: assert property (
    rd_flag |-> carry_irq_o == (wb_dat_o[7] && wb_dat_o[4])) else $error("carry irq wrong");
  a_alarm_irq_gate: assert property (
    rd_flag |-> alarm_irq_o == (wb_dat_o[0] && wb_dat_o[3])) else $error("alarm irq wrong");
  a_periodic_irq_flag: assert property (
    rd_per |-> periodic_irq_o == wb_dat_o[23]) else $error("periodic irq wrong");
  a_reserved_zero: assert property (
    rd_flag |-> wb_dat_o[6:5] == 2'h0 && wb_dat_o[2:1] == 2'h0) else $error("reserved set");
  a_adjust_round: assert property (
    wr_per && wb_dat_i[18] |=> div_reset_o && adjust_round_up_o == ($past(time_i.second) >= 8'h30)
      && adjust_round_down_o == ($past(time_i.second) < 8'h30)) else $error("adjust wrong");
  a_div_reset_pulse: assert property (
    wr_per && wb_dat_i[17] |=> div_reset_o ##1 !div_reset_o) else $error("div reset wrong");
  a_run_ctrl: assert property (
    wr_per |=> osc_enable_o == $past(wb_dat_i[19]) && count_run_o == $past(wb_dat_i[16]))
    else $error("run control wrong");
  a_alarm_cause: assert property (
    $rose(alarm_irq_o) |-> $past(events_i.counters_updated, 2) || $past(wr_take, 2))
    else $error("alarm irq without cause");
endmodule // rac_alarm_ctrl_asserts

bind rac_alarm_ctrl rac_alarm_ctrl_asserts u_chk (.*);

// ### rac_alarm_ctrl_test.sv
// Self-checking testbench for the RTC alarm and control block.
`timescale 1ns/1ps
module rac_alarm_ctrl_test;
  logic clk_i = 0, rst_i = 1, manual_rst_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [4:0] wb_adr_i = 5'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, carry_irq_o, alarm_irq_o, periodic_irq_o, osc_enable_o, count_run_o;
  logic div_reset_o, adjust_round_down_o, adjust_round_up_o;
  rac_pkg::rac_time_t time_i = '0;
  rac_pkg::rac_events_t events_i = '0;
  int mismatches = 0, samples_checked = 0, n_div = 0, n_up = 0, n_dn = 0;
  logic [4:0] aa [6] = '{rac_pkg::ADDR_SECOND_ALARM, rac_pkg::ADDR_MINUTE_ALARM,
    rac_pkg::ADDR_HOUR_ALARM, rac_pkg::ADDR_WEEKDAY_ALARM, rac_pkg::ADDR_DATE_ALARM,
    rac_pkg::ADDR_MONTH_ALARM};
  logic [7:0] am [6] = '{rac_pkg::SEC_MIN_MASK, rac_pkg::SEC_MIN_MASK, rac_pkg::HOUR_MASK,
    rac_pkg::WEEKDAY_MASK, rac_pkg::DATE_MASK, rac_pkg::MONTH_MASK};
  localparam logic [4:0] FC = rac_pkg::ADDR_FLAG_CTRL;
  localparam logic [4:0] PC = rac_pkg::ADDR_PERIOD_CTRL;
  rac_alarm_ctrl dut (.*);
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    n_div += (div_reset_o === 1'b1);
    n_up += (adjust_round_up_o === 1'b1);
    n_dn += (adjust_round_down_o === 1'b1);
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  // The lane follows address bit 1, so the byte moves with it on both directions.
  task automatic xfer(input logic [4:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= a[1] ? 4'h4 : 4'h1;
    wb_dat_i <= a[1] ? {8'h00, d, 16'h0000} : {24'h000000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 50);
    if (n >= 50) chk(8'hEE, 8'h00);
    q = a[1] ? wb_dat_o[23:16] : wb_dat_o[7:0];
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    xfer(a, 1'b0, 8'h00, q);
    chk(q, e);
  endtask
  task automatic pulse(input int k);
    @(posedge clk_i);
    events_i[8 + k] <= 1;
    @(posedge clk_i);
    events_i[8 + k] <= 0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic t_alarm_regs;
    for (int i = 0; i < 6; i++) wr(aa[i], 8'hFF);
    for (int i = 0; i < 6; i++) rd(aa[i], 8'h80 | am[i]);
    @(posedge clk_i) manual_rst_i <= 1;
    @(posedge clk_i) manual_rst_i <= 0;
    for (int i = 0; i < 6; i++) rd(aa[i], 8'h80 | am[i]);
    @(posedge clk_i) rst_i <= 1;
    @(posedge clk_i) rst_i <= 0;
    for (int i = 0; i < 6; i++) rd(aa[i], am[i]);
    rd(FC, 8'h00);
    rd(PC, 8'h09);
    chk({6'h0, osc_enable_o, count_run_o}, 8'h03);
    rd(5'h00, 8'h00);
  endtask
  // Pulse index: 0 counters updated, 1 seconds tick, 2 sub-second tick.
  task automatic t_alarm_match;
    wr(aa[0], 8'hA5);
    wr(aa[1], 8'h90);
    wr(FC, 8'h08);
    time_i.second <= 8'h25;
    time_i.minute <= 8'h11;
    pulse(0);
    rd(FC, 8'h08);
    time_i.minute <= 8'h10;
    pulse(0);
    rd(FC, 8'h09);
    chk({7'h0, alarm_irq_o}, 8'h01);
    wr(FC, 8'h09);
    rd(FC, 8'h09);
    wr(FC, 8'h08);
    rd(FC, 8'h08);
    chk({7'h0, alarm_irq_o}, 8'h00);
    wr(aa[0], 8'h25);
    wr(aa[1], 8'h10);
    wr(aa[4], 8'h31);
    rd(aa[4], 8'h31);
    pulse(0);
    rd(FC, 8'h08);
  endtask
  task automatic t_carry;
    wr(FC, 8'h10);
    pulse(2);
    rd(FC, 8'h90);
    chk({7'h0, carry_irq_o}, 8'h01);
    wr(FC, 8'h10);
    rd(FC, 8'h10);
    chk({7'h0, carry_irq_o}, 8'h00);
    pulse(1);
    rd(FC, 8'h90);
    wr(FC, 8'h10);
    wr(FC, 8'h90);
    rd(FC, 8'h90);
  endtask
  task automatic t_period;
    for (int k = 0; k < 8; k++) begin
      events_i.div_taps <= 8'h00;
      wr(PC, {1'b0, 3'(k), 4'h9});
      events_i.div_taps <= ~(8'h01 << k);
      rd(PC, {1'b0, 3'(k), 4'h9});
      events_i.div_taps <= 8'hFF;
      repeat (3) @(posedge clk_i);
      rd(PC, {k != 0, 3'(k), 4'h9});
      chk({7'h0, periodic_irq_o}, {7'h0, k != 0});
    end
  endtask
  task automatic t_adjust_reset;
    time_i.second <= 8'h29;
    wr(PC, 8'h0D);
    wr(PC, 8'h0B);
    time_i.second <= 8'h30;
    wr(PC, 8'h0D);
    repeat (2) @(posedge clk_i);
    chk({n_div[1:0], n_up[1:0], n_dn[1:0]}, 8'h35);
    rd(PC, 8'h09);
    wr(PC, 8'h08);
    chk({6'h0, osc_enable_o, count_run_o}, 8'h02);
    wr(FC, 8'h98);
    wr(PC, 8'hF9);
    rd(PC, 8'hF9);
    @(posedge clk_i) manual_rst_i <= 1;
    @(posedge clk_i) manual_rst_i <= 0;
    rd(FC, 8'h80);
    rd(PC, 8'h09);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    t_alarm_regs();
    t_alarm_match();
    t_carry();
    t_period();
    t_adjust_reset();
    report_and_stop();
  end
endmodule // rac_alarm_ctrl_test
